// *** hw/drive_pwm.sv ***
// Fan drive output: 256-count period, duty taken at each period start.
// Assumes duty_in is a plain 8-bit level on the same clock.
module drive_pwm (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Duty request
   input  wire logic [7:0] duty_in,
   // Output
   output logic            pin,
   output logic            period_start
);

   fan_ramp_pkg::pwm_st_t q; // Registered state
   fan_ramp_pkg::pwm_st_t d; // Next state

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d       = q;
      d.cnt   = 8'(q.cnt + 8'h01);
      d.start = (q.cnt == 8'hFF);
      // Duty changes only on a period boundary to avoid runt pulses
      if (q.cnt == 8'hFF) begin
         d.duty = duty_in;
         d.pin  = (duty_in != 8'h00);
      end else begin
         d.pin = (d.cnt < q.duty);
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pin          = q.pin;
   assign period_start = q.start;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_duty_taken: assert property (q.cnt == 8'hFF |=> q.duty == $past(duty_in))
      else $error("duty not taken at period start");
   a_zero_off: assert property (q.duty == 8'h00 && q.cnt != 8'hFF |=> !pin)
      else $error("zero duty drove the fan");

endmodule

// *** hw/fan_pwm_ramp_control.sv ***
// Fan drive ramp control: acoustic control register, ramped first drive,
// floor choice for three drives and gated speed-input counting.
// Assumes an AHB-Lite master on CLK and a temperature loop on the same
// clock that supplies calculated duties and below-floor levels.
//
// Added by the designer: the AHB-Lite interface to the registers.
`include "fan_ramp_map.svh"

module fan_pwm_ramp_control #(
   parameter int unsigned SLOT_CYCLES = `SLOT_CYCLES_DFLT // Cycles per time slot
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        SRST,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Temperature loop
   input  wire logic        AUTO_MODE,
   input  wire logic [2:0]  BELOW_FLOOR,
   input  wire logic [7:0]  CALC_DUTY1,
   input  wire logic [7:0]  CALC_DUTY2,
   input  wire logic [7:0]  CALC_DUTY3,
   // Speed inputs (asynchronous pins)
   input  wire logic        SPEED_INPUT_SECOND,
   input  wire logic        SPEED_INPUT_THIRD,
   input  wire logic        SPEED_INPUT_FOURTH,
   // Fan drives
   output logic             FAN_DRIVE_FIRST,
   output logic             FAN_DRIVE_SECOND,
   output logic             FAN_DRIVE_THIRD
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   fan_ramp_pkg::top_st_t q;        // Registered state
   fan_ramp_pkg::top_st_t d;        // Next state
   logic                  take;     // Address phase accepted
   logic                  in_range; // Upper address bits clear
   logic [9:0]            idx;      // Word index of address phase
   logic [7:0]            duty1;    // Ramped first drive duty
   logic [7:0]            step1;    // Current increment
   logic [2:0]            rise;     // Speed edges, second..fourth
   logic [2:0]            grouped;  // Inputs tied to the third drive

   // Duty below the floor: off or minimum, else calculated
   // Below-floor only matters in automatic mode; manual duties pass through
   function automatic logic [7:0] floor_duty(input logic auto_on,
                                             input logic below,
                                             input logic sel,
                                             input logic [7:0] min_duty,
                                             input logic [7:0] calc);
      logic [7:0] r;
      r = calc;
      if (auto_on && below) begin
         r = sel ? min_duty : 8'h00;
      end
      return r;
   endfunction

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   // Only NONSEQ or SEQ with the bus ready starts a transfer
   assign take     = HSEL && HTRANS[1] && HREADY;
   // Index 0x3FF is never mapped, so stray upper bits read as zero
   assign in_range = (HADDR[31:12] == 20'h00000);
   assign idx      = in_range ? HADDR[11:2] : 10'h3FF;
   assign step1    = fan_ramp_pkg::step_size(q.ctrl[`RATE_MSB:`RATE_LSB]);

   // Speed edges from the second sync stage only; the first may be metastable
   assign rise     = q.sp_s2 & ~q.sp_prev;
   // grouping clear
   // Bit 0 is the second input, the only one the grouping bit frees
   assign grouped  = {1'b1, 1'b1, q.ctrl[`GROUP_BIT]};

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d       = q;
      // Zero wait states: ready from the first edge after reset
      d.ready = 1'b1;
      d.resp  = 1'b0;

      // Data phase of a write: commit HWDATA
      d.wr_pend = 1'b0;
      if (q.wr_pend) begin
         unique case (q.wr_idx)
            `ACOUSTIC_IDX: d.ctrl = HWDATA[7:0];
            `MIN_DUTY_IDX: d.min  = HWDATA[23:0];
            default: ;
         endcase
      end

      // Address phase: reads see writes landing this very edge
      if (take) begin
         d.wr_pend = HWRITE;
         d.wr_idx  = idx;
         if (!HWRITE) begin
            unique case (idx)
               `ACOUSTIC_IDX:   d.rdata = {24'h000000, d.ctrl};
               `MIN_DUTY_IDX:   d.rdata = {8'h00, d.min};
               `SPEED_CNT_IDX:  d.rdata = {8'h00, q.cnt};
               `DRIVE1_NOW_IDX: d.rdata = {24'h000000, duty1};
               default:         d.rdata = 32'h00000000;
            endcase
         end
      end

      d.tgt1 = floor_duty(AUTO_MODE, BELOW_FLOOR[0], q.ctrl[`FLOOR1_BIT],
                          q.min[7:0], CALC_DUTY1);
      d.tgt2 = floor_duty(AUTO_MODE, BELOW_FLOOR[1], q.ctrl[`FLOOR2_BIT],
                          q.min[15:8], CALC_DUTY2);
      d.tgt3 = floor_duty(AUTO_MODE, BELOW_FLOOR[2], q.ctrl[`FLOOR3_BIT],
                          q.min[23:16], CALC_DUTY3);

      // Time slot timer; free running so slots stay evenly spaced
      // Limitation: the first step after enabling may come early in a slot
      if (q.slot_cnt >= SLOT_CYCLES - 1) begin
         d.slot_cnt = 32'h00000000;
         d.tick     = 1'b1;
      end else begin
         d.slot_cnt = 32'(q.slot_cnt + 32'h00000001);
         d.tick     = 1'b0;
      end

      // Two-stage synchroniser, then edge history
      d.sp_s1   = {SPEED_INPUT_FOURTH, SPEED_INPUT_THIRD, SPEED_INPUT_SECOND};
      d.sp_s2   = q.sp_s1;
      d.sp_prev = q.sp_s2;

      // grouped inputs count only while third drive is on
      for (int i = 0; i < 3; i++) begin
         if (rise[i] && (!grouped[i] || FAN_DRIVE_THIRD)) begin
            d.cnt[i*8 +: 8] = 8'(q.cnt[i*8 +: 8] + 8'h01);
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge CLK) begin
      if (SRST) begin
         // Whole state clears first; registers with reset values follow
         q      <= '0;
         q.ctrl <= `ACOUSTIC_RST;
         q.min  <= `MIN_DUTY_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Ramp and drives
   // ----------------------------------------
   // rate steers first drive
   ramp_stepper u_ramp1 (
      .clk    (CLK),
      .srst   (SRST),
      .en     (q.ctrl[`RAMP_EN_BIT]),
      .tick   (q.tick),
      .step   (step1),
      .target (q.tgt1),
      .duty   (duty1)
   );

   // First drive takes the ramped duty
   drive_pwm u_fan_drive_first (
      .clk          (CLK),
      .srst         (SRST),
      .duty_in      (duty1),
      .pin          (FAN_DRIVE_FIRST),
      .period_start ()
   );

   // Second and third drives are not ramped here
   drive_pwm u_fan_drive_second (
      .clk          (CLK),
      .srst         (SRST),
      .duty_in      (q.tgt2),
      .pin          (FAN_DRIVE_SECOND),
      .period_start ()
   );

   // Third drive also gates the speed counting
   drive_pwm u_fan_drive_third (
      .clk          (CLK),
      .srst         (SRST),
      .duty_in      (q.tgt3),
      .pin          (FAN_DRIVE_THIRD),
      .period_start ()
   );

   // Bus outputs straight from flops
   assign HRDATA    = q.rdata;
   assign HREADYOUT = q.ready;
   assign HRESP     = q.resp;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   sequence s_floor1_off;
      AUTO_MODE && BELOW_FLOOR[0] && !q.ctrl[`FLOOR1_BIT];
   endsequence

   sequence s_floor1_min;
      AUTO_MODE && BELOW_FLOOR[0] && q.ctrl[`FLOOR1_BIT];
   endsequence

   // Write: address phase, then the data phase that carries HWDATA
   sequence s_ctrl_write;
      take && HWRITE && (idx == `ACOUSTIC_IDX) ##1 1'b1;
   endsequence

   // Read with no write still landing, so the held value must come back
   sequence s_ctrl_read;
      take && !HWRITE && (idx == `ACOUSTIC_IDX) && !q.wr_pend;
   endsequence

   a_reset_value: assert property (@(posedge CLK) disable iff (1'b0)
      SRST |=> q.ctrl == 8'h00)
      else $error("control register not cleared by reset");
   a_reg_write: assert property (s_ctrl_write |=> q.ctrl == $past(HWDATA[7:0]))
      else $error("control register write lost");
   a_ctrl_readback: assert property (s_ctrl_read |=>
      HRDATA == {24'h000000, $past(q.ctrl)})
      else $error("control register read back wrong");
   a_floor1_off: assert property (s_floor1_off |=> q.tgt1 == 8'h00)
      else $error("first drive not off below floor");
   a_floor1_min: assert property (s_floor1_min |=> q.tgt1 == $past(q.min[7:0]))
      else $error("first drive not at minimum below floor");
   a_floor2_choice: assert property (AUTO_MODE && BELOW_FLOOR[1] |=>
      q.tgt2 == ($past(q.ctrl[`FLOOR2_BIT]) ? $past(q.min[15:8]) : 8'h00))
      else $error("second drive floor choice wrong");
   a_floor3_choice: assert property (AUTO_MODE && BELOW_FLOOR[2] |=>
      q.tgt3 == ($past(q.ctrl[`FLOOR3_BIT]) ? $past(q.min[23:16]) : 8'h00))
      else $error("third drive floor choice wrong");

   // Outside automatic mode every drive follows its calculated duty
   a_calc_pass1: assert property (!AUTO_MODE |=> q.tgt1 == $past(CALC_DUTY1))
      else $error("first drive ignores calculated duty");
   a_calc_pass2: assert property (!AUTO_MODE |=> q.tgt2 == $past(CALC_DUTY2))
      else $error("second drive ignores calculated duty");
   a_calc_pass3: assert property (!AUTO_MODE |=> q.tgt3 == $past(CALC_DUTY3))
      else $error("third drive ignores calculated duty");
   a_group_hold: assert property (q.ctrl[`GROUP_BIT] && rise[0] && !FAN_DRIVE_THIRD
      |=> $stable(q.cnt[7:0]))
      else $error("grouped second input counted while drive off");
   a_free_count: assert property (!q.ctrl[`GROUP_BIT] && rise[0] |=>
      q.cnt[7:0] == 8'($past(q.cnt[7:0]) + 8'h01))
      else $error("independent second input not counted");
   a_group_count: assert property (q.ctrl[`GROUP_BIT] && rise[0] && FAN_DRIVE_THIRD |=>
      q.cnt[7:0] == 8'($past(q.cnt[7:0]) + 8'h01))
      else $error("grouped second input missed while drive on");

   // Third and fourth inputs are always tied to the third drive
   a_third_gate: assert property (rise[1] && !FAN_DRIVE_THIRD |=> $stable(q.cnt[15:8]))
      else $error("third input counted while third drive off");
   a_fourth_gate: assert property (rise[2] && !FAN_DRIVE_THIRD |=> $stable(q.cnt[23:16]))
      else $error("fourth input counted while third drive off");
   a_fast_rate: assert property (q.ctrl[3:0] == 4'hF && q.tick && q.tgt1 > duty1
      && 8'(q.tgt1 - duty1) > 8'h30 |=> duty1 == 8'($past(duty1) + 8'h30))
      else $error("fastest rate not 48 per slot");
   a_zero_wait: assert property (take |=> HREADYOUT && !HRESP)
      else $error("bus answer not ready and okay");

   // Read data stands until the next read address phase
   a_rdata_hold: assert property (!(take && !HWRITE) |=> $stable(HRDATA))
      else $error("read data changed without a read");

endmodule

// *** hw/fan_ramp_map.svh ***
// Offsets, field positions, reset values and timing counts for the
// fan drive ramp control block.
// Assumes a 100 MHz CLK and word-indexed register decode.
`ifndef FAN_RAMP_MAP_SVH
`define FAN_RAMP_MAP_SVH

// ----------------------------------------
// Register word indexes (byte address = 4 x index)
// ----------------------------------------
`define ACOUSTIC_IDX     10'h062
`define MIN_DUTY_IDX     10'h064
`define SPEED_CNT_IDX    10'h065
`define DRIVE1_NOW_IDX   10'h066

// ----------------------------------------
// Acoustic control fields
// ----------------------------------------
`define RATE_MSB         2
`define RATE_LSB         0
`define RAMP_EN_BIT      3
`define GROUP_BIT        4
`define FLOOR1_BIT       5
`define FLOOR2_BIT       6
`define FLOOR3_BIT       7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACOUSTIC_RST     8'h00
`define MIN_DUTY_RST     24'h000000

// ----------------------------------------
// Timing: 35 s for the 33%..100% span (170 duty steps) at one step per slot
// ----------------------------------------
`define CLK_HZ           64'd100000000
`define RAMP_TIME_S      64'd35
`define RAMP_SPAN        64'd170
`define SLOT_CYCLES_DFLT 32'(`RAMP_TIME_S * `CLK_HZ / `RAMP_SPAN)

`endif

// *** hw/fan_ramp_pkg.sv ***
// Types and the ramp step decode for the fan drive ramp control block.
// Assumes the constants of fan_ramp_map.svh.
package fan_ramp_pkg;

   // Ramp stepper state
   typedef struct packed {
      logic [7:0] duty;
   } step_st_t;

   // Drive output state
   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] duty;
      logic       pin;
      logic       start;
   } pwm_st_t;

   // Top state: bus, registers, targets, slot timer, speed counters
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [23:0] min;
      logic        wr_pend;
      logic [9:0]  wr_idx;
      logic [31:0] rdata;
      logic        ready;
      logic        resp;
      logic [7:0]  tgt1;
      logic [7:0]  tgt2;
      logic [7:0]  tgt3;
      logic [31:0] slot_cnt;
      logic        tick;
      logic [2:0]  sp_s1;
      logic [2:0]  sp_s2;
      logic [2:0]  sp_prev;
      logic [23:0] cnt;
   } top_st_t;

   // Duty increment per time slot for a ramp-rate code
   function automatic logic [7:0] step_size(input logic [2:0] code);
      logic [7:0] s;
      s = 8'h01;
      unique case (code)
         3'h0: s = 8'h01;
         3'h1: s = 8'h02;
         3'h2: s = 8'h03;
         3'h3: s = 8'h05;
         3'h4: s = 8'h08;
         3'h5: s = 8'h0C;
         3'h6: s = 8'h18;
         3'h7: s = 8'h30;
      endcase
      return s;
   endfunction

endpackage

// *** hw/ramp_stepper.sv ***
// Moves a duty value toward its target, one bounded step per time slot.
// Assumes tick is a one-cycle pulse from the slot timer on the same clock.
module ramp_stepper (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Control
   input  wire logic       en,
   input  wire logic       tick,
   input  wire logic [7:0] step,
   input  wire logic [7:0] target,
   // Result
   output logic [7:0]      duty
);

   fan_ramp_pkg::step_st_t q;   // Registered state
   fan_ramp_pkg::step_st_t d;   // Next state
   logic [7:0]             gap; // Distance to target

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d   = q;
      gap = (q.duty < target) ? 8'(target - q.duty) : 8'(q.duty - target);
      if (!en) begin
         d.duty = target;
      end else if (tick) begin
         // Clamp last step so the target is never passed
         if (gap <= step) begin
            d.duty = target;
         end else if (q.duty < target) begin
            d.duty = 8'(q.duty + step);
         end else begin
            d.duty = 8'(q.duty - step);
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign duty = q.duty;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_last_step;
      en && tick && (gap <= step);
   endsequence

   a_reach_target: assert property (s_last_step |=> duty == $past(target))
      else $error("ramp did not land on target");
   a_step_bound: assert property (en && tick && (gap > step) |=>
      ((duty > $past(duty)) ? 8'(duty - $past(duty)) : 8'($past(duty) - duty))
      == $past(step))
      else $error("ramp step differs from selected increment");
   a_hold_slot: assert property (en && !tick |=> $stable(duty))
      else $error("ramp moved outside a time slot");
   a_direct_apply: assert property (!en |=> duty == $past(target))
      else $error("unramped duty not applied");

endmodule

// *** tb/fan_speed_model.sv ***
// Behavioural model of three fans' speed outputs.
// Assumes nothing of the bench clock: the pulses run free, unrelated in phase.
module fan_speed_model #(
   parameter int HALF_NS = 170 // Half period of the fastest fan
) (
   // Speed pulses
   output logic spd_second,
   output logic spd_third,
   output logic spd_fourth
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // Pulse generators
   // ----------------------------------------
   // Start low, as a stopped fan would
   initial begin
      spd_second = 1'b0;
      spd_third  = 1'b0;
      spd_fourth = 1'b0;
   end

   // Odd offsets keep the fans off the clock grid and off each other
   always #(HALF_NS) spd_second = ~spd_second;
   always #(HALF_NS + 23) spd_third = ~spd_third;
   always #(HALF_NS + 41) spd_fourth = ~spd_fourth;
endmodule

// *** tb/test_fan_pwm_ramp_control.sv ***
// Self-checking bench for the fan drive ramp control block.
// Assumes an AHB-Lite master of its own and a shortened ramp time slot.
`include "fan_ramp_map.svh"

module test_fan_pwm_ramp_control;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // Constants and signals
   // ----------------------------------------
   localparam int          SLOT  = 20; // Short slot keeps the run brief
   localparam logic [31:0] CTRL_A = {20'h0, `ACOUSTIC_IDX, 2'b00};
   localparam logic [31:0] MIN_A  = {20'h0, `MIN_DUTY_IDX, 2'b00};
   localparam logic [31:0] SPD_A  = {20'h0, `SPEED_CNT_IDX, 2'b00};
   localparam logic [31:0] NOW_A  = {20'h0, `DRIVE1_NOW_IDX, 2'b00};
   localparam logic [31:0] UNMAP_A = 32'h00000100; // No register here
   localparam int          STEPS [8] = '{1, 2, 3, 5, 8, 12, 24, 48};

   logic        CLK, SRST, HSEL, HWRITE, HREADYOUT, HRESP, AUTO_MODE;
   logic [31:0] HADDR, HWDATA, HRDATA;
   logic [1:0]  HTRANS;
   logic [2:0]  BELOW_FLOOR;
   logic [7:0]  CALC_DUTY1, CALC_DUTY2, CALC_DUTY3;
   logic        SPEED_INPUT_SECOND, SPEED_INPUT_THIRD, SPEED_INPUT_FOURTH;
   logic        FAN_DRIVE_FIRST, FAN_DRIVE_SECOND, FAN_DRIVE_THIRD;
   int          n_mismatch;    // Failed comparisons
   int          total_checks;  // All comparisons
   logic [31:0] rd;            // Last read word

   // ----------------------------------------
   // Design, fans and clock
   // ----------------------------------------
   fan_pwm_ramp_control #(.SLOT_CYCLES(SLOT)) uut (
      .CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
      .AUTO_MODE(AUTO_MODE), .BELOW_FLOOR(BELOW_FLOOR), .CALC_DUTY1(CALC_DUTY1),
      .CALC_DUTY2(CALC_DUTY2), .CALC_DUTY3(CALC_DUTY3),
      .SPEED_INPUT_SECOND(SPEED_INPUT_SECOND), .SPEED_INPUT_THIRD(SPEED_INPUT_THIRD),
      .SPEED_INPUT_FOURTH(SPEED_INPUT_FOURTH), .FAN_DRIVE_FIRST(FAN_DRIVE_FIRST),
      .FAN_DRIVE_SECOND(FAN_DRIVE_SECOND), .FAN_DRIVE_THIRD(FAN_DRIVE_THIRD));

   fan_speed_model fans (
      .spd_second(SPEED_INPUT_SECOND),
      .spd_third(SPEED_INPUT_THIRD),
      .spd_fourth(SPEED_INPUT_FOURTH));

   // 100 MHz clock
   always #5 CLK = ~CLK;

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // One single AHB-Lite transfer; entered and left just after a rising edge
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
      HSEL   <= 1'b1;
      HTRANS <= 2'h2;
      HADDR  <= a;
      HWRITE <= wr;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HSEL   <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      r = HRDATA;
      chk({31'h0, HRESP}, 32'h0, "bus response");
   endtask

   // Compare and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   // High cycles of one drive over one full 256-cycle period
   task automatic hi_count(input int which, output logic [31:0] n);
      n = 32'h0;
      repeat (256) begin
         @(posedge CLK);
         n = n + {31'h0, (which == 1) ? FAN_DRIVE_FIRST :
                         (which == 2) ? FAN_DRIVE_SECOND : FAN_DRIVE_THIRD};
      end
   endtask

   // Which speed counters moved over a window (bit 0 second .. bit 2 fourth)
   task automatic spd(input logic [2:0] exp_nz);
      logic [31:0] a;
      logic [31:0] b;
      logic [7:0]  d;
      ahb(1'b0, SPD_A, 32'h0, a);
      repeat (2000) @(posedge CLK);
      ahb(1'b0, SPD_A, 32'h0, b);
      for (int k = 0; k < 3; k++) begin
         d = b[8*k +: 8] - a[8*k +: 8];
         chk({31'h0, d != 8'h00}, {31'h0, exp_nz[k]}, "speed count moved");
      end
   endtask

   // Counts, verdict and end of run
   task automatic print_verdict;
      $display("Checks: %0d, mismatches: %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   // Whole sequence needs about 36000 cycles
   initial begin
      repeat (90000) @(posedge CLK);
      n_mismatch++;
      print_verdict();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int prev;
      int tgt;
      int e;
      logic [31:0] n;
      CLK = 1'b0; SRST = 1'b1; HSEL = 1'b0; HWRITE = 1'b0; HTRANS = 2'h0;
      HADDR = 32'h0; HWDATA = 32'h0; AUTO_MODE = 1'b0; BELOW_FLOOR = 3'h0;
      CALC_DUTY1 = 8'h00; CALC_DUTY2 = 8'h00; CALC_DUTY3 = 8'h00;
      n_mismatch = 0; total_checks = 0;
      repeat (5) @(posedge CLK);
      SRST <= 1'b0;
      @(posedge CLK);
      // Register reset, access, upper bits, unmapped place
      ahb(1'b0, CTRL_A, 32'h0, rd); chk(rd, 32'h0, "control reset");
      ahb(1'b1, CTRL_A, 32'hFFFFFFFF, rd);
      ahb(1'b0, CTRL_A, 32'h0, rd); chk(rd, 32'h000000FF, "control rw");
      ahb(1'b1, CTRL_A, 32'h0, rd);
      ahb(1'b1, UNMAP_A, 32'hFF, rd);
      ahb(1'b0, UNMAP_A, 32'h0, rd); chk(rd, 32'h0, "unmapped read");
      ahb(1'b0, CTRL_A, 32'h0, rd); chk(rd, 32'h0, "unmapped write");
      // Unramped duty lands at once, then drives one period
      CALC_DUTY1 <= 8'h5A;
      repeat (3) @(posedge CLK);
      ahb(1'b0, NOW_A, 32'h0, rd); chk(rd, 32'h5A, "direct duty");
      repeat (512) @(posedge CLK);
      hi_count(1, n); chk(n, 32'h5A, "drive one high");
      CALC_DUTY1 <= 8'h00;
      repeat (4) @(posedge CLK);
      // Ramp up and down at every rate code, watching every step
      for (int c = 0; c < 8; c++) begin
         ahb(1'b1, CTRL_A, 32'(8'h08 | 8'(c)), rd);
         for (int dir = 0; dir < 2; dir++) begin
            tgt = dir ? 0 : 200;
            prev = dir ? 200 : 0;
            CALC_DUTY1 <= 8'(tgt);
            for (int g = 0; g < 3000 && prev != tgt; g++) begin
               ahb(1'b0, NOW_A, 32'h0, rd);
               if (rd !== 32'(prev)) begin
                  e = dir ? prev - STEPS[c] : prev + STEPS[c];
                  e = (e < 0) ? 0 : (e > 200) ? 200 : e;
                  chk(rd, 32'(e), "ramp step");
                  prev = int'(rd[7:0]);
               end
            end
            chk(32'(prev), 32'(tgt), "ramp end");
         end
      end
      // Below the floor in automatic mode: off or minimum, per drive
      AUTO_MODE <= 1'b1;
      BELOW_FLOOR <= 3'h7;
      CALC_DUTY2 <= 8'h80;
      CALC_DUTY3 <= 8'h80;
      ahb(1'b1, MIN_A, 32'h00302010, rd);
      for (int f = 0; f < 8; f++) begin
         ahb(1'b1, CTRL_A, 32'(f << 5), rd);
         ahb(1'b0, CTRL_A, 32'h0, rd); chk(rd, 32'(f << 5), "floor bits");
         repeat (600) @(posedge CLK);
         ahb(1'b0, NOW_A, 32'h0, rd); chk(rd, f[0] ? 32'h10 : 32'h0, "floor one");
         hi_count(2, n); chk(n, f[1] ? 32'h20 : 32'h0, "floor two");
         hi_count(3, n); chk(n, f[2] ? 32'h30 : 32'h0, "floor three");
      end
      // Speed grouping with the third drive held low, then high
      AUTO_MODE <= 1'b0;
      BELOW_FLOOR <= 3'h0;
      CALC_DUTY3 <= 8'h00;
      ahb(1'b1, CTRL_A, 32'h00, rd);
      repeat (600) @(posedge CLK);
      spd(3'b001);
      ahb(1'b1, CTRL_A, 32'h10, rd);
      repeat (10) @(posedge CLK);
      spd(3'b000);
      CALC_DUTY3 <= 8'hFF;
      repeat (600) @(posedge CLK);
      spd(3'b111);
      // Mid-run reset with the grouping bit and minimums set
      SRST <= 1'b1;
      repeat (5) @(posedge CLK);
      SRST <= 1'b0;
      @(posedge CLK);
      ahb(1'b0, CTRL_A, 32'h0, rd); chk(rd, 32'h0, "control after reset");
      ahb(1'b0, MIN_A, 32'h0, rd); chk(rd, 32'h0, "minimum after reset");
      print_verdict();
   end
endmodule
